// ===== src/rxs_pkg.sv
// Shared constants and types for the receive strength and filter block
package rxs_pkg;
	localparam int unsigned CLK_HZ   = 20_000_000;
	localparam int unsigned XTAL_HZ  = 32_000_000;
	localparam int          CODE_W   = 8;
	localparam int          SAMP_W   = 12;
	localparam int          TAPS     = 16;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_FWIDTH  = 8'h04;
	localparam logic [7:0] ADDR_GREF    = 8'h08;
	localparam logic [7:0] ADDR_LIVE    = 8'h0C;
	localparam logic [7:0] ADDR_PACKET  = 8'h10;
	localparam logic [7:0] ADDR_THERMAL = 8'h14;
	localparam logic [7:0] ADDR_AGCREF  = 8'h18;
	localparam logic [7:0] ADDR_STATUS  = 8'h1C;
	// Control and filter width field positions
	localparam int CTRL_OFS_LSB = 0;
	localparam int CTRL_AVG_LSB = 5;
	localparam int CTRL_TDIS    = 8;
	localparam int CTRL_CAL     = 9;
	localparam int FW_EXP_LSB   = 0;
	localparam int FW_MANT_LSB  = 3;
	// Reset values
	localparam logic [4:0] RST_OFFSET = 5'h00;
	localparam logic [2:0] RST_AVG    = 3'h2;
	localparam logic [4:0] RST_FWIDTH = 5'h15;
	localparam logic [5:0] RST_GREF   = 6'h00;
	// Mantissa codes and exponent range
	localparam logic [1:0] MANT_16 = 2'b00;
	localparam logic [1:0] MANT_20 = 2'b01;
	localparam logic [1:0] MANT_24 = 2'b10;
	localparam int EXP_MIN = 1;
	localparam int EXP_MAX = 7;
	// Gain reference terms, tenths of a dB
	localparam int AGC_FLOOR  = -1740;
	localparam int AGC_SNR    = 80;
	localparam int AGC_2XTAL  = 781;
	localparam int AGC_M16    = 120;
	localparam int AGC_M20    = 130;
	localparam int AGC_M24    = 138;
	localparam int AGC_OCTAVE = 30;
	localparam int AGC_EXPOFS = 2;
	// Operating modes seen on the mode pins, and calibration states
	localparam logic [2:0] MODE_SLEEP   = 3'h0;
	localparam logic [2:0] MODE_STANDBY = 3'h1;
	typedef enum logic [1:0] {
		RXS_IDLE = 2'b00,
		RXS_CAL  = 2'b01
	} rxs_cal_e;
endpackage : rxs_pkg

// ===== src/rxs_links_if.sv
// Links between the block top and its averaging and filter units
`timescale 1ns/10ps
interface rxs_avg_if;
	import rxs_pkg::*;
	logic              samp_valid;
	logic [CODE_W-1:0] samp;
	logic [2:0]        select;
	logic              restart;
	logic              avg_valid;
	logic [CODE_W-1:0] avg;
	modport ctl (output samp_valid, samp, select, restart,
		input avg_valid, avg);
	modport unit (input samp_valid, samp, select, restart,
		output avg_valid, avg);
endinterface : rxs_avg_if

interface rxs_fir_if;
	import rxs_pkg::*;
	logic                     in_valid;
	logic signed [SAMP_W-1:0] in_data;
	logic                     out_valid;
	logic signed [SAMP_W-1:0] out_data;
	modport ctl (output in_valid, in_data, input out_valid, out_data);
	modport unit (input in_valid, in_data, output out_valid, out_data);
endinterface : rxs_fir_if

// ===== src/rxs_averager.sv
// Block averager over 2^(select+1) level samples
`timescale 1ns/10ps
module rxs_averager
	import rxs_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	rxs_avg_if.unit   lnk
);
	typedef struct packed {
		logic [CODE_W+8:0] acc;
		logic [8:0]        cnt;
		logic              valid;
		logic [CODE_W-1:0] avg;
	} rxs_avg_s;

	rxs_avg_s st_q;
	rxs_avg_s st_d;
	logic [CODE_W+8:0] sum;
	logic [8:0]        target;
	logic [3:0]        shamt;

	always_comb
	begin
		st_d = st_q;
		st_d.valid = 1'b0;
		sum = st_q.acc + (CODE_W+9)'(lnk.samp);
		// Four bits, so select 7 shifts by eight instead of wrapping to zero
		shamt = {1'b0, lnk.select} + 4'h1;
		target = 9'(10'h001 << shamt);
		if (lnk.restart)
		begin
			st_d.acc = '0;
			st_d.cnt = '0;
		end
		else if (lnk.samp_valid)
		begin
			if (st_q.cnt + 9'h001 == target)
			begin
				st_d.avg = CODE_W'(sum >> shamt);
				st_d.valid = 1'b1;
				st_d.acc = '0;
				st_d.cnt = '0;
			end
			else
			begin
				st_d.acc = sum;
				st_d.cnt = st_q.cnt + 9'h001;
			end
		end
	end

	always_ff @(posedge clock)
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;

	assign lnk.avg_valid = st_q.valid;
	assign lnk.avg = st_q.avg;
endmodule : rxs_averager

// ===== src/rxs_fir.sv
// Sixteen-tap channel filter on the digitised sample stream
`timescale 1ns/10ps
module rxs_fir
	import rxs_pkg::*;
#(
	parameter logic signed [7:0] COEF [TAPS] = '{8'sh02, 8'sh04, 8'sh08,
		8'sh0C, 8'sh12, 8'sh18, 8'sh1C, 8'sh1E, 8'sh1E, 8'sh1C, 8'sh18,
		8'sh12, 8'sh0C, 8'sh08, 8'sh04, 8'sh02}
)
(
	input  wire logic clock,
	input  wire logic rst,
	rxs_fir_if.unit   lnk
);
	typedef struct packed {
		logic [TAPS-1:0][SAMP_W-1:0] line;
		logic                        valid;
		logic [SAMP_W-1:0]           out;
	} rxs_fir_s;

	rxs_fir_s st_q;
	rxs_fir_s st_d;
	logic signed [SAMP_W+12:0] mac;

	always_comb
	begin
		st_d = st_q;
		st_d.valid = 1'b0;
		mac = '0;
		if (lnk.in_valid)
		begin
			st_d.line = {st_q.line[TAPS-2:0], lnk.in_data};
			for (int i = 0; i < TAPS; i++)
				mac = mac + $signed(st_d.line[i]) * COEF[i];
			// Coefficients sum near 256, so drop eight bits of gain
			st_d.out = SAMP_W'(mac >>> 8);
			st_d.valid = 1'b1;
		end
	end

	always_ff @(posedge clock)
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;

	assign lnk.out_valid = st_q.valid;
	assign lnk.out_data = $signed(st_q.out);
endmodule : rxs_fir

// ===== src/rxs_top.sv
// Receive strength measurement, channel filter and thermal monitor
//
// Summary of operation
// - Report strength as absolute code, half-dB steps, within filter band.
// - Code is minus twice input level plus offset; dBm is minus code/2.
// - Offset field takes -16 to +15 dB in 1 dB steps; here each step moves the half-dB code by one.
// - Average over 2^(select+1) samples, 2 up to 256.
// - Averaged response time is 2^(select+1)/(4*bandwidth kHz) ms.
// - Strength calibration runs whenever calibration is launched; here a launch while a calibration is running is ignored.
// - Packet strength averages live strength; live readable at any time.
// - Live strength refreshes once per reciprocal of bandwidth.
// - Channel filter is a sixteen-tap FIR.
// - Bandwidth is crystal over mantissa times 2^(exponent+2).
// - Mantissa 00/01/10 mean 16/20/24; exponents 1..7; rest reserved.
// - Thermal monitor runs in every mode but sleep and standby.
// - Thermal monitor on after reset, off by disable bit, stores reading.
// - Gain reference: -174 + 10log(2*bw) + 8 + adjustment.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module rxs_top
	import rxs_pkg::*;
(
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic                          pready,
	output logic [31:0]                   prdata,
	output logic                          pslverr,
	input  wire logic                     level_valid,
	input  wire logic [CODE_W-1:0]        level_raw,
	input  wire logic                     iq_valid,
	input  wire logic signed [SAMP_W-1:0] iq_data,
	input  wire logic                     header_ok_flag,
	input  wire logic                     receive_done_flag,
	input  wire logic [2:0]               op_mode,
	input  wire logic                     thermal_valid,
	input  wire logic [7:0]               thermal_sample,
	output logic                          filt_valid,
	output logic signed [SAMP_W-1:0]      filt_data,
	output logic                          thermal_enable
);
	typedef struct packed {
		logic              pready;
		logic [31:0]       prdata;
		logic              pslverr;
		logic [4:0]        level_offset;
		logic [2:0]        sample_average_select;
		logic              thermal_monitor_disable;
		logic [1:0]        filter_bw_mantissa;
		logic [2:0]        filter_bw_exponent;
		logic [5:0]        gain_ref_adjust;
		logic [CODE_W-1:0] avg_latest;
		logic              avg_seen;
		logic [CODE_W-1:0] live_level;
		logic [CODE_W-1:0] packet_run;
		logic              in_packet;
		logic [CODE_W-1:0] packet_level;
		logic [7:0]        thermal_reading;
		logic [23:0]       refresh_cnt;
		rxs_cal_e          cal_state;
		logic              cal_restart;
		logic              filt_valid;
		logic [SAMP_W-1:0] filt_data;
		logic              thermal_enable;
	} rxs_top_s;

	rxs_top_s st_q;
	rxs_top_s st_d;

	rxs_avg_if avg_lnk ();
	rxs_fir_if fir_lnk ();

	// Mantissa value; reserved code 11 falls back to the widest divisor
	function automatic logic [4:0] mant_value(input logic [1:0] code);
		case (code)
			MANT_16: mant_value = 5'h10;
			MANT_20: mant_value = 5'h14;
			MANT_24: mant_value = 5'h18;
			default: mant_value = 5'h18;
		endcase
	endfunction : mant_value

	function automatic logic bw_reserved(input logic [1:0] m,
		input logic [2:0] e);
		bw_reserved = (m == 2'b11) || (int'(e) < EXP_MIN) ||
			(int'(e) > EXP_MAX);
	endfunction : bw_reserved

	// Clock cycles in one reciprocal of the filter bandwidth
	function automatic logic [23:0] refresh_period(input logic [1:0] m,
		input logic [2:0] e);
		longint div;
		longint cyc;
		div = longint'(mant_value(m)) << (int'(e) + AGC_EXPOFS);
		cyc = (div * longint'(CLK_HZ)) / longint'(XTAL_HZ);
		if (cyc < 1)
			cyc = 1;
		refresh_period = 24'(cyc);
	endfunction : refresh_period

	// Gain reference level in tenths of a dBm
	function automatic logic [15:0] agc_ref(input logic [1:0] m,
		input logic [2:0] e, input logic [5:0] adj);
		int mt;
		int r;
		case (m)
			MANT_16: mt = AGC_M16;
			MANT_20: mt = AGC_M20;
			default: mt = AGC_M24;
		endcase
		r = AGC_FLOOR + AGC_2XTAL - mt -
			AGC_OCTAVE * (int'(e) + AGC_EXPOFS) +
			AGC_SNR + 10 * int'(adj);
		agc_ref = 16'(r);
	endfunction : agc_ref

	// Offset is two's complement, so -16..+15 half-dB steps cover the full field
	function automatic logic [CODE_W-1:0] apply_offset(
		input logic [CODE_W-1:0] raw, input logic [4:0] ofs);
		logic signed [CODE_W+1:0] s;
		s = $signed({2'b00, raw}) +
			(CODE_W+2)'($signed(ofs));
		if (s < 0)
			apply_offset = '0;
		else if (s > $signed((CODE_W+2)'({CODE_W{1'b1}})))
			apply_offset = '1;
		else
			apply_offset = CODE_W'(s);
	endfunction : apply_offset

	function automatic logic [31:0] read_word(input rxs_top_s s,
		input logic [7:0] a);
		read_word = '0;
		case (a)
			ADDR_CTRL:
			begin
				read_word[CTRL_OFS_LSB +: 5] = s.level_offset;
				read_word[CTRL_AVG_LSB +: 3] = s.sample_average_select;
				read_word[CTRL_TDIS] = s.thermal_monitor_disable;
				read_word[CTRL_CAL] = (s.cal_state == RXS_CAL);
			end
			ADDR_FWIDTH:
			begin
				read_word[FW_EXP_LSB +: 3] = s.filter_bw_exponent;
				read_word[FW_MANT_LSB +: 2] = s.filter_bw_mantissa;
			end
			ADDR_GREF:    read_word[5:0] = s.gain_ref_adjust;
			ADDR_LIVE:    read_word[CODE_W-1:0] = s.live_level;
			ADDR_PACKET:  read_word[CODE_W-1:0] = s.packet_level;
			ADDR_THERMAL: read_word[7:0] = s.thermal_reading;
			ADDR_AGCREF:  read_word[15:0] = agc_ref(s.filter_bw_mantissa,
				s.filter_bw_exponent, s.gain_ref_adjust);
			ADDR_STATUS:
			begin
				read_word[0] = bw_reserved(s.filter_bw_mantissa,
					s.filter_bw_exponent);
				read_word[1] = (s.cal_state == RXS_CAL);
				read_word[2] = s.thermal_enable;
				read_word[3] = s.in_packet;
			end
			default: read_word = '0;
		endcase
	endfunction : read_word

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a[1:0] == 2'b00) && (a <= ADDR_STATUS);
	endfunction : addr_mapped

	logic wr_take;
	logic cal_launch;
	logic refresh_tick;

	always_comb
	begin
		st_d = st_q;
		// Access phase answers on its second cycle so prdata is a flop
		wr_take = psel && penable && st_q.pready && pwrite &&
			addr_mapped(paddr);
		cal_launch = wr_take && (paddr == ADDR_CTRL) && pwdata[CTRL_CAL];
		st_d.pready = psel && penable && !st_q.pready;
		st_d.prdata = '0;
		st_d.pslverr = 1'b0;
		if (psel && penable && !st_q.pready)
		begin
			st_d.pslverr = !addr_mapped(paddr);
			if (!pwrite)
				st_d.prdata = read_word(st_q, paddr);
		end

		if (wr_take)
		begin
			case (paddr)
				ADDR_CTRL:
				begin
					st_d.level_offset = pwdata[CTRL_OFS_LSB +: 5];
					st_d.sample_average_select =
						pwdata[CTRL_AVG_LSB +: 3];
					st_d.thermal_monitor_disable = pwdata[CTRL_TDIS];
				end
				ADDR_FWIDTH:
				begin
					st_d.filter_bw_exponent = pwdata[FW_EXP_LSB +: 3];
					st_d.filter_bw_mantissa = pwdata[FW_MANT_LSB +: 2];
				end
				ADDR_GREF: st_d.gain_ref_adjust = pwdata[5:0];
				default: st_d.gain_ref_adjust = st_q.gain_ref_adjust;
			endcase
		end

		// Calibration flushes the averager and waits for a fresh average
		st_d.cal_restart = 1'b0;
		case (st_q.cal_state)
			RXS_IDLE:
				if (cal_launch)
				begin
					st_d.cal_state = RXS_CAL;
					st_d.cal_restart = 1'b1;
					st_d.avg_seen = 1'b0;
				end
			RXS_CAL:
				if (avg_lnk.avg_valid)
					st_d.cal_state = RXS_IDLE;
			default: st_d.cal_state = RXS_IDLE;
		endcase

		if (avg_lnk.avg_valid)
		begin
			st_d.avg_latest = avg_lnk.avg;
			st_d.avg_seen = 1'b1;
		end

		// Live value follows the bandwidth so a read sees 1/bw old data
		refresh_tick = (st_q.refresh_cnt == 24'h00_0000);
		if (refresh_tick)
		begin
			st_d.refresh_cnt = refresh_period(st_q.filter_bw_mantissa,
				st_q.filter_bw_exponent) - 24'h00_0001;
			if (st_q.avg_seen)
				st_d.live_level = st_q.avg_latest;
		end
		else
			st_d.refresh_cnt = st_q.refresh_cnt - 24'h00_0001;

		// Packet value is a running quarter-weight average of live value
		if (header_ok_flag)
		begin
			st_d.in_packet = 1'b1;
			st_d.packet_run = st_q.live_level;
		end
		else if (st_q.in_packet && refresh_tick)
			st_d.packet_run = CODE_W'((({2'b00, st_q.packet_run} * 3) +
				{2'b00, st_q.live_level}) >> 2);
		if (receive_done_flag && st_q.in_packet)
		begin
			// A header in the same cycle opens the next packet, so it wins
			st_d.in_packet = header_ok_flag;
			st_d.packet_level = st_q.packet_run;
		end

		st_d.thermal_enable = !st_q.thermal_monitor_disable &&
			(op_mode != MODE_SLEEP) &&
			(op_mode != MODE_STANDBY);
		if (st_q.thermal_enable && thermal_valid)
			st_d.thermal_reading = thermal_sample;

		st_d.filt_valid = fir_lnk.out_valid;
		if (fir_lnk.out_valid)
			st_d.filt_data = fir_lnk.out_data;
	end

	always_ff @(posedge clock)
		if (rst)
		begin
			st_q <= '0;
			st_q.level_offset <= RST_OFFSET;
			st_q.sample_average_select <= RST_AVG;
			st_q.filter_bw_mantissa <= RST_FWIDTH[FW_MANT_LSB +: 2];
			st_q.filter_bw_exponent <= RST_FWIDTH[FW_EXP_LSB +: 3];
			st_q.gain_ref_adjust <= RST_GREF;
			st_q.cal_state <= RXS_IDLE;
		end
		else
			st_q <= st_d;

	assign avg_lnk.samp_valid = level_valid;
	assign avg_lnk.samp = apply_offset(level_raw, st_q.level_offset);
	assign avg_lnk.select = st_q.sample_average_select;
	assign avg_lnk.restart = st_q.cal_restart;
	assign fir_lnk.in_valid = iq_valid;
	assign fir_lnk.in_data = iq_data;

	rxs_averager u_avg (
		.clock (clock),
		.rst   (rst),
		.lnk   (avg_lnk)
	);

	rxs_fir u_fir (
		.clock (clock),
		.rst   (rst),
		.lnk   (fir_lnk)
	);

	assign pready = st_q.pready;
	assign prdata = st_q.prdata;
	assign pslverr = st_q.pslverr;
	assign filt_valid = st_q.filt_valid;
	assign filt_data = $signed(st_q.filt_data);
	assign thermal_enable = st_q.thermal_enable;
endmodule : rxs_top

// ===== tb/rxs_top_asserts.sv
// Port assertions for the receive strength and filter block
`timescale 1ns/10ps
module rxs_top_asserts
	import rxs_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        iq_valid,
	input wire logic        filt_valid,
	input wire logic [2:0]  op_mode,
	input wire logic        thermal_enable
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_answer;
		psel && !penable |=> !pready ##1 pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("answer not on second access cycle");
	property p_one;
		pready |=> !pready;
	endproperty
	a_one: assert property (p_one)
		else $error("ready held longer than one cycle");
	property p_err;
		pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'b00);
	endproperty
	a_err: assert property (p_err)
		else $error("error response does not match address");
	property p_errq;
		pslverr |-> pready;
	endproperty
	a_errq: assert property (p_errq)
		else $error("error response without ready");
	property p_rdq;
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_rdq: assert property (p_rdq)
		else $error("read data not cleared outside answer");
	// Filter register and output register add one cycle each
	property p_filt;
		iq_valid |=> ##1 filt_valid;
	endproperty
	a_filt: assert property (p_filt)
		else $error("filter output missing two cycles after input");
	property p_filtq;
		!iq_valid |=> ##1 !filt_valid;
	endproperty
	a_filtq: assert property (p_filtq)
		else $error("filter output without input");
	property p_sleep;
		op_mode == MODE_SLEEP || op_mode == MODE_STANDBY |=> !thermal_enable;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("thermal monitor running in sleep or standby");
	property p_therm_on;
		$fell(rst) && op_mode > MODE_STANDBY |-> ##[0:1] thermal_enable;
	endproperty
	a_therm_on: assert property (p_therm_on)
		else $error("thermal monitor not on after reset");
endmodule : rxs_top_asserts

bind rxs_top rxs_top_asserts u_asserts (.clock(clock), .rst(rst),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .iq_valid(iq_valid),
	.filt_valid(filt_valid), .op_mode(op_mode),
	.thermal_enable(thermal_enable));

// ===== tb/rxs_front_end.sv
// Front end model: level codes and channel samples
`timescale 1ns/10ps
module rxs_front_end
	import rxs_pkg::*;
(
	input  wire logic                     clock,
	input  wire logic                     lvl_on,
	input  wire logic                     slow,
	input  wire logic [CODE_W-1:0]        lvl_set,
	input  wire logic                     iq_req,
	input  wire logic signed [SAMP_W-1:0] iq_in,
	output logic                          level_valid,
	output logic [CODE_W-1:0]             level_raw,
	output logic                          iq_valid,
	output logic signed [SAMP_W-1:0]      iq_data
);
	logic ph;
	initial
	begin
		{ph, level_valid, iq_valid} = '0;
		level_raw = '0;
		iq_data = '0;
	end
	// Idle data lines toggle so a stale value is never mistaken for a sample
	always @(posedge clock)
	begin
		ph <= ~ph;
		level_valid <= lvl_on && (!slow || ph);
		level_raw <= (lvl_on && (!slow || ph)) ? lvl_set : ~level_raw;
		iq_valid <= iq_req;
		iq_data <= iq_req ? iq_in : ~iq_data;
	end
endmodule : rxs_front_end

// ===== tb/rx_signal_strength_and_filter_test.sv
// Self-checking bench for the receive strength and filter block
`timescale 1ns/10ps
module rx_signal_strength_and_filter_test;
	import rxs_pkg::*;
	localparam logic signed [7:0] CF [TAPS] = '{8'sh02, 8'sh04, 8'sh08,
		8'sh0C, 8'sh12, 8'sh18, 8'sh1C, 8'sh1E, 8'sh1E, 8'sh1C, 8'sh18,
		8'sh12, 8'sh0C, 8'sh08, 8'sh04, 8'sh02};
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} rxs_exp_s;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, bad;
	logic lvl_on, slow, iq_req, hdr, done, t_v, t_en, lv, iv, fv;
	logic [7:0] paddr, t_s, lvl_set, lr, r, s;
	logic [31:0] pwdata, prdata;
	logic [4:0] o;
	logic [2:0] op_mode;
	logic signed [SAMP_W-1:0] iq_in, iqd, fd, x;
	logic signed [SAMP_W-1:0] hist [TAPS];
	logic signed [SAMP_W-1:0] fq[$];
	rxs_exp_s aq[$];
	rxs_exp_s ex;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int v, acc;
	rxs_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .level_valid(lv),
		.level_raw(lr), .iq_valid(iv), .iq_data(iqd),
		.header_ok_flag(hdr), .receive_done_flag(done), .op_mode(op_mode),
		.thermal_valid(t_v), .thermal_sample(t_s), .filt_valid(fv),
		.filt_data(fd), .thermal_enable(t_en));
	rxs_front_end u_fe (.clock(clock), .lvl_on(lvl_on), .slow(slow),
		.lvl_set(lvl_set), .iq_req(iq_req), .iq_in(iq_in),
		.level_valid(lv), .level_raw(lr), .iq_valid(iv), .iq_data(iqd));
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic chk(input string n, input logic [31:0] sn, e);
		checks_done++;
		if (sn !== e)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, sn);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, ed, m);
		aq.push_back('{ed, m, a > 8'h1C || a[1:0] != 2'b00});
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0000_0000, 32'hFFFF_FFFF);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		apb(1'b0, a, 32'h0000_0000, e, m);
	endtask : rd
	task automatic tpulse(input logic [7:0] d);
		@(posedge clock);
		t_v <= 1'b1;
		t_s <= d;
		@(posedge clock);
		t_v <= 1'b0;
	endtask : tpulse
	function automatic int agc(input int c, input int adj);
		int m;
		m = c[4:3] == 0 ? AGC_M16 : (c[4:3] == 1 ? AGC_M20 : AGC_M24);
		return AGC_FLOOR + AGC_2XTAL - m + AGC_SNR + 10 * adj
			- AGC_OCTAVE * (c[2:0] + AGC_EXPOFS);
	endfunction : agc
	// Results are paired with notes in issue order; both paths keep order
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (pready === 1'b1)
		begin
			chk("response queue", 32'(aq.size() > 0), 32'h0000_0001);
			ex = aq.pop_front();
			chk("prdata", prdata & ex.m, ex.d & ex.m);
			chk("pslverr", 32'(pslverr), 32'(ex.e));
		end
		if (fv === 1'b1)
			chk("filt_data", 32'(fd), 32'(fq.pop_front()));
		if (cyc == 20000)
		begin
			n_errors++;
			finish_test();
		end
	end
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, lvl_on, slow, iq_req, hdr, done, t_v} = '0;
		{paddr, pwdata, lvl_set, t_s, iq_in} = '0;
		op_mode = 3'h2;
		for (int j = 0; j < TAPS; j++) hist[j] = '0;
		void'($urandom(99));
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(ADDR_CTRL, 32'h0000_0040, 32'hFFFF_FFFF);
		rd(ADDR_FWIDTH, 32'h0000_0015, 32'hFFFF_FFFF);
		rd(ADDR_LIVE, 32'h0000_0000, 32'hFFFF_FFFF);
		rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_000F);
		rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
		wr(8'h02, 32'h0000_0001);
		$display("test reset done");
		for (int k = 0; k < 40; k++)
		begin
			x = SAMP_W'($urandom);
			for (int j = TAPS - 1; j > 0; j--) hist[j] = hist[j - 1];
			hist[0] = x;
			acc = 0;
			for (int j = 0; j < TAPS; j++) acc += CF[j] * hist[j];
			fq.push_back(SAMP_W'(acc >>> 8));
			@(posedge clock);
			iq_req <= 1'b1;
			iq_in <= x;
		end
		@(posedge clock);
		iq_req <= 1'b0;
		$display("test filter done");
		for (int c = 0; c < 32; c++)
		begin
			bad = c[4:3] == 2'b11 || c[2:0] == 3'h0;
			wr(ADDR_FWIDTH, 32'(c));
			rd(ADDR_FWIDTH, 32'(c), 32'h0000_001F);
			rd(ADDR_STATUS, 32'(bad), 32'h0000_0001);
			rd(ADDR_AGCREF, 32'(agc(c, 0)),
				bad ? 0 : 32'hFFFF);
		end
		wr(ADDR_FWIDTH, 32'h0000_0015);
		wr(ADDR_GREF, 32'h0000_0005);
		rd(ADDR_AGCREF, 32'(agc(21, 5)), 32'h0000_FFFF);
		$display("test bandwidth done");
		// Fastest valid refresh keeps the averaging runs short
		wr(ADDR_FWIDTH, 32'h0000_0001);
		// Refresh loaded at reset still counts 1920 cycles of the old width
		repeat (2000) @(posedge clock);
		lvl_on <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			r = 8'($urandom);
			o = 5'($urandom);
			if (i == 0) {r, o} = {8'h05, 5'h10};
			if (i == 1) {r, o} = {8'hFA, 5'h0F};
			v = int'(r) + int'($signed(o));
			v = v < 0 ? 0 : (v > 255 ? 255 : v);
			lvl_set <= r;
			slow <= i[0];
			wr(ADDR_CTRL, 32'(o) | (32'(i) << CTRL_AVG_LSB) | 32'h200);
			repeat ((4 << i) + 200) @(posedge clock);
			wr(ADDR_LIVE, 32'hFFFF_FFFF);
			rd(ADDR_LIVE, 32'(v), 32'h0000_00FF);
			rd(ADDR_CTRL, 32'(o) | (32'(i) << 5), 32'h3FF);
		end
		@(posedge clock);
		hdr <= 1'b1;
		@(posedge clock);
		hdr <= 1'b0;
		repeat (300) @(posedge clock);
		rd(ADDR_STATUS, 32'h0000_000C, 32'h0000_000E);
		rd(ADDR_LIVE, 32'(v), 32'h0000_00FF);
		@(posedge clock);
		done <= 1'b1;
		@(posedge clock);
		done <= 1'b0;
		rd(ADDR_PACKET, 32'(v), 32'h0000_00FF);
		$display("test level done");
		s = 8'($urandom);
		tpulse(s);
		rd(ADDR_THERMAL, 32'(s), 32'h0000_00FF);
		wr(ADDR_CTRL, 32'h0000_0100);
		tpulse(~s);
		rd(ADDR_THERMAL, 32'(s), 32'h0000_00FF);
		rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0004);
		wr(ADDR_CTRL, 32'h0000_0000);
		op_mode <= MODE_SLEEP;
		repeat (3) @(posedge clock);
		chk("thermal_enable", 32'(t_en), 32'h0000_0000);
		op_mode <= MODE_STANDBY;
		repeat (3) @(posedge clock);
		chk("thermal_enable", 32'(t_en), 32'h0000_0000);
		op_mode <= 3'h3;
		repeat (3) @(posedge clock);
		chk("thermal_enable", 32'(t_en), 32'h0000_0001);
		$display("test thermal done");
		finish_test();
	end
endmodule : rx_signal_strength_and_filter_test
